// ### hw/tpwm_pkg.sv
// tpwm_pkg: register map, field positions, reset values and constants of the timer/pwm block
package tpwm_pkg;
    // register word indexes; the byte address is four times the index
    localparam logic [7:0] IDX_COUNTER   = 8'h10;   // counter_value
    localparam logic [7:0] IDX_CTRL_ONE  = 8'h11;   // timer_control_one
    localparam logic [7:0] IDX_CTRL_TWO  = 8'h12;   // timer_control_two
    localparam logic [7:0] IDX_DUTY_LOW  = 8'h13;   // pwm_duty_low
    localparam logic [7:0] IDX_HIGH_RELD = 8'h20;   // high_reload_bits holding register
    localparam int         ADDR_W        = 8;       // avalon word address width
    // timer_control_one fields
    localparam int BIT_TIMER_EN  = 0;
    localparam int BIT_RELOAD    = 1;
    localparam int BIT_ONE_SHOT  = 2;
    localparam int BIT_POLARITY  = 6;
    localparam int BIT_PWM_OE    = 7;
    // timer_control_two fields
    localparam int BIT_PSEL_LO   = 0;
    localparam int BIT_PS_DIS    = 3;
    localparam int BIT_EXT_EDGE  = 4;
    localparam int BIT_CLK_SRC   = 5;
    // high_reload_bits fields
    localparam int BIT_DUTY_HI   = 0;
    localparam int BIT_RELD_HI   = 4;
    // reset values
    localparam logic [7:0] RST_CTRL_ONE  = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO  = 8'h3F;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    // counter constants
    localparam int         CNT_W         = 10;
    localparam logic [9:0] CNT_ALL_ONES  = 10'h3FF;
    localparam logic [9:0] CNT_ZERO      = 10'h000;
    localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;
endpackage : tpwm_pkg

// ### hw/tpwm_prescaler.sv
// tpwm_prescaler: divide-by-2^(sel+1) tick generator for the timer clock events
`timescale 1ns/100ps
`default_nettype none
module tpwm_prescaler #(
    parameter int PS_W = 8                   // prescaler counter width
) (
    input  wire logic       clk_sys_i,       // system clock
    input  wire logic       rst_n_i,         // synchronised reset, active low
    input  wire logic       event_i,         // raw timer clock event
    input  wire logic       disable_i,       // prescaler bypass, active high
    input  wire logic [2:0] select_i,        // divide select
    output logic            tick_o           // prescaled event
);
    if (PS_W != 8) begin : g_bad_width
        $error("tpwm_prescaler: PS_W must be 8");
    end

    logic [PS_W-1:0] ps_cnt;                 // free prescaler count
    logic [PS_W-1:0] next_ps_cnt;
    logic [PS_W-1:0] mask;                   // low bits that must all be set

    // next count and tick: tick on the event that wraps the selected low bits
    always_comb begin
        mask        = PS_W'((9'h001 << (select_i + 4'h1)) - 9'h001);
        next_ps_cnt = ps_cnt;
        tick_o      = 1'b0;
        if (disable_i) begin
            next_ps_cnt = '0;                // held clear while bypassed
            tick_o      = event_i;
        end else if (event_i) begin
            next_ps_cnt = ps_cnt + PS_W'(1);
            tick_o      = ((ps_cnt & mask) == mask);
        end
    end

    // register the count; select changes mid-count may give a short period
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) ps_cnt <= '0;
        else          ps_cnt <= next_ps_cnt;
    end
endmodule : tpwm_prescaler
`default_nettype wire

// ### hw/tpwm_timer.sv
// tpwm_timer: 10-bit down counter with prescaler and pwm channel, avalon-mm slave
// Function
// - counter read returns low eight counter bits
// - counter write loads high reload bits plus byte
// - non-stop no reload: underflow loads 0x3FF
// - non-stop reload: underflow loads reload value
// - one-shot counts down once then stops
// - reload select matters only in non-stop mode
// - polarity bit one makes pwm active low
// - output enable routes pwm to port pad
// - prescaler divides by two to the select plus one
// - external edge bit picks falling or rising edge
// - clock source bit picks external or instruction clock
// - frame from reload, duty from high bits and duty
`timescale 1ns/100ps
`default_nettype none
module tpwm_timer #(
    parameter int INSTR_DIV = 2                      // system clocks per instruction clock
) (
    input  wire logic        clk_sys_i,              // system clock, 100 MHz
    input  wire logic        rst_n_i,                // asynchronous reset, active low
    input  wire logic [7:0]  avs_address,            // word address
    input  wire logic        avs_read,               // read request
    input  wire logic        avs_write,              // write request
    input  wire logic [31:0] avs_writedata,          // write data, low byte used
    input  wire logic [3:0]  avs_byteenable,         // byte lanes
    output logic [31:0]      avs_readdata,           // read data
    output logic             avs_waitrequest,        // stall
    input  wire logic        external_clock_pin_i,   // external timer clock pin
    input  wire logic        gpio_out_i,             // port bit value when used as gpio
    input  wire logic        gpio_oe_n_i,            // port bit enable when used as gpio
    output logic             port_a_bit_two_pad_o,   // pad output value
    output logic             port_a_bit_two_pad_oe_n_o, // pad output enable, low drives
    output logic             pwm_channel_o           // pwm waveform after polarity
);
    if (INSTR_DIV < 1 || INSTR_DIV > 255) begin : g_bad_div
        $error("tpwm_timer: INSTR_DIV out of range");
    end

    // reset release through two flops
    // so every flop below leaves reset on one clock edge
    logic rst_meta_n;                                // first stage
    logic rst_n;                                     // synchronised reset

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // --- register file state ---
    logic [7:0] ctrl_one;                            // timer_control_one
    logic [7:0] ctrl_two;                            // timer_control_two
    logic [7:0] duty_low;                            // pwm_duty_low
    logic [7:0] high_reload_bits;                    // high reload and duty bits
    logic [7:0] reload_low;                          // low reload byte written via counter

    logic [7:0] next_ctrl_one;
    logic [7:0] next_ctrl_two;
    logic [7:0] next_duty_low;
    logic [7:0] next_high_reload_bits;
    logic [7:0] next_reload_low;

    logic       ack;                                 // one-cycle answer phase
    logic       next_ack;

    logic [31:0] next_readdata;
    logic        load_cnt;                           // counter write strobe

    // access accepted when request seen and not yet answered
    // writes act at the first edge; the master holds them to the answer
    logic req;

    assign req             = (avs_read | avs_write) & ~ack;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;

    // decode a word address into a register hit
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
        hit = (addr == idx);
    endfunction : hit

    // --- timer state ---
    logic [9:0] count;                               // 10-bit down counter
    logic [9:0] next_count;

    logic       stopped;                             // one-shot done flag
    logic       next_stopped;

    // register write and read-data next values
    always_comb begin
        next_ctrl_one         = ctrl_one;
        next_ctrl_two         = ctrl_two;
        next_duty_low         = duty_low;
        next_high_reload_bits = high_reload_bits;
        next_reload_low       = reload_low;
        next_ack              = req;                 // answer one cycle after request
        next_readdata         = avs_readdata;
        load_cnt              = 1'b0;

        if (req && avs_write && avs_byteenable[0]) begin
            if (hit(avs_address, tpwm_pkg::IDX_COUNTER)) begin
                next_reload_low = avs_writedata[7:0];
                load_cnt        = 1'b1;
            end else if (hit(avs_address, tpwm_pkg::IDX_CTRL_ONE)) begin
                next_ctrl_one = avs_writedata[7:0];
            end else if (hit(avs_address, tpwm_pkg::IDX_CTRL_TWO)) begin
                next_ctrl_two = avs_writedata[7:0];  // divide change is software's duty
            end else if (hit(avs_address, tpwm_pkg::IDX_DUTY_LOW)) begin
                next_duty_low = avs_writedata[7:0];
            end else if (hit(avs_address, tpwm_pkg::IDX_HIGH_RELD)) begin
                next_high_reload_bits = avs_writedata[7:0];
            end
        end

        // read data are registered and stand in the answer cycle
        if (req && avs_read) begin
            if (hit(avs_address, tpwm_pkg::IDX_COUNTER))
                next_readdata = {24'h00_0000, count[7:0]};
            else if (hit(avs_address, tpwm_pkg::IDX_CTRL_ONE))
                next_readdata = {24'h00_0000, ctrl_one[7:6], 3'b000, ctrl_one[2:0]};
            else if (hit(avs_address, tpwm_pkg::IDX_CTRL_TWO))
                next_readdata = {24'h00_0000, 2'b00, ctrl_two[5:0]};
            else if (hit(avs_address, tpwm_pkg::IDX_HIGH_RELD))
                next_readdata = {24'h00_0000, high_reload_bits};
            else
                next_readdata = tpwm_pkg::UNMAPPED_RD;  // duty is write-only, reads zero
        end
    end

    // register file and bus answer flops
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one         <= tpwm_pkg::RST_CTRL_ONE;
            ctrl_two         <= tpwm_pkg::RST_CTRL_TWO;
            duty_low         <= tpwm_pkg::RST_BYTE;
            high_reload_bits <= tpwm_pkg::RST_BYTE;
            reload_low       <= tpwm_pkg::RST_BYTE;
            ack              <= 1'b0;
            avs_readdata     <= 32'h0000_0000;
        end else begin
            ctrl_one         <= next_ctrl_one;
            ctrl_two         <= next_ctrl_two;
            duty_low         <= next_duty_low;
            high_reload_bits <= next_high_reload_bits;
            reload_low       <= next_reload_low;
            ack              <= next_ack;
            avs_readdata     <= next_readdata;
        end
    end

    // field views
    logic       timer_enable_bit;
    logic       reload_select_bit;
    logic       one_shot_bit;
    logic       pwm_polarity_bit;
    logic       pwm_output_enable_bit;

    logic       clock_source_bit;
    logic       external_edge_bit;
    logic       prescaler_disable_bit;
    logic [2:0] prescaler_divide_select;
    logic [9:0] reload_value;                        // frame length
    logic [9:0] duty_value;                          // duty threshold

    assign timer_enable_bit        = ctrl_one[tpwm_pkg::BIT_TIMER_EN];
    assign reload_select_bit       = ctrl_one[tpwm_pkg::BIT_RELOAD];
    assign one_shot_bit            = ctrl_one[tpwm_pkg::BIT_ONE_SHOT];
    assign pwm_polarity_bit        = ctrl_one[tpwm_pkg::BIT_POLARITY];
    assign pwm_output_enable_bit   = ctrl_one[tpwm_pkg::BIT_PWM_OE];

    assign prescaler_divide_select = ctrl_two[tpwm_pkg::BIT_PSEL_LO +: 3];
    assign prescaler_disable_bit   = ctrl_two[tpwm_pkg::BIT_PS_DIS];
    assign external_edge_bit       = ctrl_two[tpwm_pkg::BIT_EXT_EDGE];
    assign clock_source_bit        = ctrl_two[tpwm_pkg::BIT_CLK_SRC];

    assign reload_value = {high_reload_bits[tpwm_pkg::BIT_RELD_HI +: 2], reload_low};
    assign duty_value   = {high_reload_bits[tpwm_pkg::BIT_DUTY_HI +: 2], duty_low};

    // external pin: two-flop synchroniser, then a third flop for edge detect
    logic ext_meta;                                  // first stage, read only by ext_sync
    logic ext_sync;                                  // synchronised level
    logic ext_prev;                                  // previous synchronised level
    // reset leaves the timer off, so a first edge after it is harmless
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= external_clock_pin_i;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // instruction clock tick from a system-clock divider
    logic [7:0] instr_cnt;                           // divider count
    logic [7:0] next_instr_cnt;
    logic       instr_tick;                          // one instruction clock

    always_comb begin
        instr_tick     = (instr_cnt == 8'(INSTR_DIV - 1));
        next_instr_cnt = instr_tick ? 8'h00 : instr_cnt + 8'h01;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) instr_cnt <= 8'h00;
        else        instr_cnt <= next_instr_cnt;
    end

    // pick edge and source
    logic ext_event;                                 // selected pin edge
    logic raw_event;                                 // chosen timer clock event
    logic tick;                                      // prescaled event

    always_comb begin
        ext_event = external_edge_bit ? (ext_prev & ~ext_sync)   // falling
                                      : (~ext_prev & ext_sync);  // rising
        raw_event = clock_source_bit ? ext_event : instr_tick;
    end

    // prescaler on the chosen event, bypassed while disabled
    tpwm_prescaler #(
        .PS_W (8)
    ) tpwm_prescaler_i (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .event_i   (raw_event),
        .disable_i (prescaler_disable_bit),
        .select_i  (prescaler_divide_select),
        .tick_o    (tick)
    );

    // counter next value: load on write, else count per mode
    // a write beats a tick in the same cycle: software restarts the count
    always_comb begin
        next_count   = count;
        next_stopped = stopped;

        if (load_cnt) begin
            next_count   = {high_reload_bits[tpwm_pkg::BIT_RELD_HI +: 2],
                            avs_writedata[7:0]};
            next_stopped = 1'b0;
        end else if (timer_enable_bit && tick && !stopped) begin
            if (count != tpwm_pkg::CNT_ZERO) begin
                next_count = count - 10'h001;
            end else if (one_shot_bit) begin
                next_stopped = 1'b1;
            end else if (reload_select_bit) begin
                next_count = reload_value;
            end else begin
                next_count = tpwm_pkg::CNT_ALL_ONES;
            end
        end

        if (!one_shot_bit) next_stopped = 1'b0;              // leaving one-shot rearms
    end

    // counter flops; counter resets to zero as its power-up value is undefined
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            count   <= tpwm_pkg::CNT_ZERO;
            stopped <= 1'b0;
        end else begin
            count   <= next_count;
            stopped <= next_stopped;
        end
    end

    // pwm and pad outputs, all from flops
    logic pwm_active;
    logic next_pwm;
    logic next_pad;
    logic next_pad_oe_n;

    always_comb begin
        pwm_active    = timer_enable_bit && (count <= duty_value);
        next_pwm      = pwm_active ^ pwm_polarity_bit;
        next_pad      = pwm_output_enable_bit ? next_pwm : gpio_out_i;
        next_pad_oe_n = pwm_output_enable_bit ? 1'b0 : gpio_oe_n_i;
    end

    // output flops; the pad is released while reset holds
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pwm_channel_o             <= 1'b0;
            port_a_bit_two_pad_o      <= 1'b0;
            port_a_bit_two_pad_oe_n_o <= 1'b1;
        end else begin
            pwm_channel_o             <= next_pwm;
            port_a_bit_two_pad_o      <= next_pad;
            port_a_bit_two_pad_oe_n_o <= next_pad_oe_n;
        end
    end
endmodule : tpwm_timer
`default_nettype wire

// ### verif/tpwm_timer_chk.sv
// tpwm_timer_chk: bus, read-back and pad routing assertions for the timer/pwm block
`timescale 1ns/100ps
`default_nettype none
module tpwm_timer_chk #(
    parameter int INSTR_DIV = 2                      // kept in step with the design
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        external_clock_pin_i,
    input wire logic        gpio_out_i,
    input wire logic        gpio_oe_n_i,
    input wire logic        port_a_bit_two_pad_o,
    input wire logic        port_a_bit_two_pad_oe_n_o,
    input wire logic        pwm_channel_o
);
    logic [1:0] up_q;                                // edges since reset release, saturating
    wire logic  rdy;                                 // internal two-flop reset has let go
    // the design keeps its own reset two edges longer, so hold judgement until then
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    assign rdy = (up_q == 2'h3);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    AST_WAIT_ONE: assert property (rdy && (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("stall lasted more than one cycle");
    AST_RD_STALL: assert property (rdy && $rose(avs_read)
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("read not answered in one cycle");
    AST_WR_STALL: assert property (rdy && $rose(avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("write not answered in one cycle");
    AST_RD_UPPER: assert property (rdy |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data above the low byte not zero");
    AST_RD_HOLD: assert property (rdy && $changed(avs_readdata) |-> $past(avs_read))
        else $error("read data moved without a read");
    AST_DUTY_RD: assert property (rdy && avs_read && avs_waitrequest
        && avs_address == tpwm_pkg::IDX_DUTY_LOW |=> avs_readdata == 32'h0000_0000)
        else $error("duty register read back");
    AST_UNMAP_RD: assert property (rdy && avs_read && avs_waitrequest
        && !(avs_address inside {8'h10, 8'h11, 8'h12, 8'h13, 8'h20})
        |=> avs_readdata == tpwm_pkg::UNMAPPED_RD) else $error("unmapped read not zero");
    AST_PAD_OE: assert property (rdy && port_a_bit_two_pad_oe_n_o |-> $past(gpio_oe_n_i))
        else $error("pad released while port asked to drive");
    AST_PAD_VAL: assert property (rdy && !port_a_bit_two_pad_oe_n_o && $past(gpio_oe_n_i)
        |-> port_a_bit_two_pad_o == pwm_channel_o
        || port_a_bit_two_pad_o == $past(pwm_channel_o)) else $error("pad not showing pwm");
    // main scenarios reached
    cover property (rdy && !port_a_bit_two_pad_oe_n_o && port_a_bit_two_pad_o);
    cover property (rdy && $rose(pwm_channel_o));
    cover property (rdy && avs_write && !avs_waitrequest);
endmodule : tpwm_timer_chk
bind tpwm_timer tpwm_timer_chk #(.INSTR_DIV(INSTR_DIV)) tpwm_timer_chk_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .external_clock_pin_i(external_clock_pin_i),
    .gpio_out_i(gpio_out_i), .gpio_oe_n_i(gpio_oe_n_i),
    .port_a_bit_two_pad_o(port_a_bit_two_pad_o),
    .port_a_bit_two_pad_oe_n_o(port_a_bit_two_pad_oe_n_o), .pwm_channel_o(pwm_channel_o));
`default_nettype wire

// ### verif/tpwm_ext_pin_model.sv
// tpwm_ext_pin_model: external clock source toggling the timer clock pin in bursts
`timescale 1ns/100ps
`default_nettype none
module tpwm_ext_pin_model (
    input  wire logic       clk_sys_i,               // bench clock
    input  wire logic       start_i,                 // load a burst
    input  wire logic [3:0] toggles_i,               // pin transitions in the burst
    output logic            pin_o,                   // clock pin, still between bursts
    output logic            busy_o                   // burst in progress
);
    logic [3:0] left_q = 4'h0;                       // transitions still to make
    logic [2:0] div_q  = 3'h0;                       // slows edges past the synchroniser
    logic       pin_q  = 1'b0;                       // pin level, idles where it stopped
    // one transition every eight clocks so no edge is lost in the two-flop sync
    always @(posedge clk_sys_i) begin
        if (start_i) begin
            left_q <= toggles_i;
        end else if (left_q != 4'h0) begin
            div_q <= div_q + 3'h1;
            if (div_q == 3'h7) begin
                pin_q  <= ~pin_q;
                left_q <= left_q - 4'h1;
            end
        end
    end
    assign pin_o  = pin_q;
    assign busy_o = (left_q != 4'h0);
endmodule : tpwm_ext_pin_model
`default_nettype wire

// ### verif/tpwm_timer_tb.sv
// tpwm_timer_tb: directed scenarios for counting modes, prescaler, clock pin and pwm
`timescale 1ns/100ps
`default_nettype none
module tpwm_timer_tb;
    localparam logic [7:0] A_CNT = tpwm_pkg::IDX_COUNTER;    // counter byte
    localparam logic [7:0] A_C1  = tpwm_pkg::IDX_CTRL_ONE;   // control one
    localparam logic [7:0] A_C2  = tpwm_pkg::IDX_CTRL_TWO;   // control two
    localparam logic [7:0] A_HR  = tpwm_pkg::IDX_HIGH_RELD;  // high reload bits
    logic        clk_sys_i, rst_n_i, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address, v;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable, tog;
    logic        ext_pin, gpio_out, gpio_oe_n, pad_o, pad_oe_n, pwm, start, busy;
    int          n_errors = 0, tests_run = 0, cyc = 0, k, t0;
    tpwm_timer #(.INSTR_DIV(2)) tpwm_timer_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .external_clock_pin_i(ext_pin), .gpio_out_i(gpio_out), .gpio_oe_n_i(gpio_oe_n),
        .port_a_bit_two_pad_o(pad_o), .port_a_bit_two_pad_oe_n_o(pad_oe_n),
        .pwm_channel_o(pwm));
    tpwm_ext_pin_model tpwm_ext_pin_model_i (.clk_sys_i(clk_sys_i), .start_i(start),
        .toggles_i(tog), .pin_o(ext_pin), .busy_o(busy));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    task results;
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask : chk
    task timeout;
        $display("CHECK FAILED %0t wait ran out", $time);
        n_errors++;
        results();
    endtask : timeout
    // one avalon cycle: hold everything until waitrequest is seen low at an edge
    task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        if (avs_waitrequest !== 1'b0) timeout();
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys_i);
    endtask : xfer
    task wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00, 4'hF);
        chk(q, {24'h00_0000, e});
    endtask : rd
    // poll the counter until its low byte moves away from v
    task wait_chg;
        int n;
        n = 0;
        do begin
            xfer(1'b0, A_CNT, 8'h00, 4'hF);
            n++;
        end while (q[7:0] === v && n < 300);
        if (q[7:0] === v) timeout();
        v = q[7:0];
    endtask : wait_chg
    task burst(input logic [3:0] n);
        start <= 1'b1;
        tog <= n;
        @(posedge clk_sys_i);
        start <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        for (k = 0; busy === 1'b1 && k < 200; k++) @(posedge clk_sys_i);
        if (busy === 1'b1) timeout();
        repeat (8) @(posedge clk_sys_i);
    endtask : burst
    // count high cycles of pwm and pad over two whole frames of 32 clocks
    task hi_count(input int e);
        int np, nd;
        np = 0;
        nd = 0;
        repeat (8) @(posedge clk_sys_i);
        repeat (64) begin
            @(negedge clk_sys_i);
            if (pwm === 1'b1) np++;
            if (pad_o === 1'b1) nd++;
        end
        chk(np, e);
        chk(nd, e);
    endtask : hi_count
    task t_regs;
        rd(A_C1, tpwm_pkg::RST_CTRL_ONE);
        rd(A_C2, tpwm_pkg::RST_CTRL_TWO);
        xfer(1'b1, A_C1, 8'hC7, 4'hE);
        rd(A_C1, 8'h00);
        rd(tpwm_pkg::IDX_DUTY_LOW, 8'h00);
        rd(8'h3F, 8'h00);
    endtask : t_regs
    task t_hold;
        wr(A_C2, 8'h08);
        wr(A_HR, 8'h30);
        wr(A_CNT, 8'hA5);
        rd(A_CNT, 8'hA5);
        repeat (20) @(posedge clk_sys_i);
        rd(A_CNT, 8'hA5);
    endtask : t_hold
    task t_modes;
        wr(A_C2, 8'h00);
        wr(A_HR, 8'h10);
        wr(A_CNT, 8'h02);
        wr(A_C1, 8'h03);
        v = 8'h02;
        wait_chg();
        wait_chg();
        wait_chg();
        chk(v, 8'hFF);
        for (k = 0; v !== 8'h00 && k < 300; k++) wait_chg();
        if (v !== 8'h00) timeout();
        wait_chg();
        chk(v, 8'h02);
        wr(A_C1, 8'h00);
        wr(A_HR, 8'h00);
        wr(A_CNT, 8'h01);
        wr(A_C1, 8'h01);
        v = 8'h01;
        wait_chg();
        wait_chg();
        chk(v, 8'hFF);
        wr(A_C1, 8'h00);
        wr(A_CNT, 8'h02);
        wr(A_C1, 8'h07);
        v = 8'h02;
        wait_chg();
        wait_chg();
        chk(v, 8'h00);
        repeat (20) rd(A_CNT, 8'h00);
    endtask : t_modes
    task t_presc;
        wr(A_C1, 8'h01);
        for (int s = 0; s < 8; s++) begin
            wr(A_C2, 8'h08 | 8'(s));
            wr(A_C2, 8'(s));
            xfer(1'b0, A_CNT, 8'h00, 4'hF);
            v = q[7:0];
            wait_chg();
            t0 = cyc;
            wait_chg();
            chk(32'(cyc - t0 + 4 >= (4 << s) && cyc - t0 <= (4 << s) + 4), 32'h0000_0001);
            wr(A_C2, 8'h08 | 8'(s));
        end
    endtask : t_presc
    task t_ext;
        wr(A_C2, 8'h08);
        wr(A_C1, 8'h00);
        wr(A_CNT, 8'h10);
        wr(A_C2, 8'h38);
        wr(A_C1, 8'h01);
        repeat (20) @(posedge clk_sys_i);
        rd(A_CNT, 8'h10);
        burst(4'h3);
        rd(A_CNT, 8'h0F);
        wr(A_C2, 8'h28);
        burst(4'h3);
        rd(A_CNT, 8'h0E);
    endtask : t_ext
    task t_pwm;
        wr(A_C2, 8'h08);
        wr(A_C2, 8'h00);
        wr(A_C1, 8'h00);
        wr(tpwm_pkg::IDX_DUTY_LOW, 8'h01);
        wr(A_CNT, 8'h07);
        wr(A_C1, 8'h83);
        hi_count(16);
        wr(A_C1, 8'hC3);
        hi_count(48);
        wr(A_HR, 8'h01);
        hi_count(0);
        wr(A_C1, 8'h03);
        gpio_out <= 1'b1;
        gpio_oe_n <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk({pad_o, pad_oe_n}, 32'h0000_0002);
    endtask : t_pwm
    initial begin
        rst_n_i = 1'b0;
        {avs_read, avs_write, start, gpio_out} = 4'h0;
        {avs_address, avs_writedata, avs_byteenable, tog} = '0;
        gpio_oe_n = 1'b1;
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        t_regs();
        t_hold();
        t_modes();
        t_presc();
        t_ext();
        t_pwm();
        results();
    end
endmodule : tpwm_timer_tb
`default_nettype wire
